/* File: adcis_port.sv */
// serial target port of a delta-sigma converter with wishbone side registers
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "adcis_defs.svh"
module adcis_port
    import adcis_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // serial bus pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    // address strap pins, pre-sensed by the pad: high pin as three levels, low pin as two
    input wire adcis_straps_t STRAPS,
    input wire logic ADDR_SEL_LO_OR_EXT_CLK_PIN,
    // converter core handshake
    input wire logic CONV_DONE,
    input wire logic [`ADCIS_RES_W-1:0] CONV_RESULT,
    output logic CONV_START,
    output logic CONV_BUSY,
    output logic EXT_CLK_SEL,
    output logic NULL_TICK,
    output adcis_cfg_t CFG,
    // classic wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O
);
    adcis_state_t state_ff, nxt_state;
    logic scl_d_ff, sda_d_ff;
    logic [7:0] sh_in_ff;
    logic [3:0] bit_ff;
    logic [`ADCIS_RES_W-1:0] sh_out_ff;
    logic [5:0] rd_cnt_ff;
    logic rd_ff;
    logic wrote_ff;
    logic sda_o_ff, sda_oe_ff;
    logic busy_ff;
    logic start_ff;
    adcis_cfg_t cfg_ff;
    logic ext_ff;
    logic [19:0] gap_ff;
    logic [3:0] edges_ff;
    logic pin_d_ff;
    logic [12:0] div_ff;
    logic tick_ff;
    logic [31:0] wb_dat_ff;
    logic wb_ack_ff;
    logic sw_start_ff;
    logic [6:0] own_addr;

    // bus edges and conditions seen on synchronous samples
    wire scl_rise = SCL_I & ~scl_d_ff;
    wire scl_fall = ~SCL_I & scl_d_ff;
    wire start_c = SCL_I & scl_d_ff & sda_d_ff & ~SDA_I;
    wire stop_c = SCL_I & scl_d_ff & ~sda_d_ff & SDA_I;
    wire pin_edge = ADDR_SEL_LO_OR_EXT_CLK_PIN ^ pin_d_ff;

    // address from straps: high pin three-state, low pin two-state, low bit forced to 1 under external clock
    wire [1:0] hi_code = STRAPS.hi_low ? 2'h0 : (STRAPS.hi_high ? 2'h1 : 2'h2);
    wire addr_sel_lo_bit = ext_ff ? 1'b1 : STRAPS.lo_high;
    assign own_addr = `ADCIS_ADDR_BASE + {4'h0, hi_code, addr_sel_lo_bit};
    // address sits above the direction bit once all eight bits are in
    wire [6:0] rx_addr = sh_in_ff[7:1];
    wire addr_hit = (rx_addr == own_addr) | (rx_addr == `ADCIS_GLOBAL_ADDR);
    wire rd_done = rd_ff & (rd_cnt_ff == `ADCIS_RES_BITS);

    // serial state machine, advanced on scl edges
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ADCIS_IDLE: nxt_state = ADCIS_IDLE;
            ADCIS_ADDR: begin
                if (scl_fall && bit_ff == 4'h8) begin
                    nxt_state = (addr_hit && !busy_ff) ? ADCIS_AACK : ADCIS_IDLE;
                end
            end
            ADCIS_AACK: if (scl_fall) nxt_state = rd_ff ? ADCIS_RDAT : ADCIS_WDAT;
            ADCIS_WDAT: if (scl_fall && bit_ff == 4'h8) nxt_state = ADCIS_WACK;
            ADCIS_WACK: if (scl_fall) nxt_state = ADCIS_IDLE;
            ADCIS_RDAT: if (scl_fall && bit_ff == 4'h8) nxt_state = ADCIS_RACK;
            ADCIS_RACK: begin
                if (scl_rise) nxt_state = (SDA_I || rd_done) ? ADCIS_IDLE : ADCIS_RACK;
                else if (scl_fall) nxt_state = ADCIS_RDAT;
            end
            default: nxt_state = ADCIS_IDLE;
        endcase
        if (start_c) nxt_state = ADCIS_ADDR;
        else if (stop_c) nxt_state = ADCIS_IDLE;
    end

    // sample registers and state
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            pin_d_ff <= 1'b0;
            state_ff <= ADCIS_IDLE;
        end else begin
            scl_d_ff <= SCL_I;
            sda_d_ff <= SDA_I;
            pin_d_ff <= ADDR_SEL_LO_OR_EXT_CLK_PIN;
            state_ff <= nxt_state;
        end
    end

    // receive shifter and bit counter
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || start_c) begin
            sh_in_ff <= 8'h00;
            bit_ff <= 4'h0;
        end else if (scl_rise && (state_ff == ADCIS_ADDR || state_ff == ADCIS_WDAT)) begin
            sh_in_ff <= {sh_in_ff[6:0], SDA_I};
            bit_ff <= bit_ff + 4'h1;
        end else if (scl_fall && bit_ff == 4'h8) begin
            bit_ff <= 4'h0;
        end else if (scl_rise && state_ff == ADCIS_RDAT) begin
            bit_ff <= bit_ff + 4'h1;
        end
    end

    // direction bit and received configuration
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            rd_ff <= 1'b0;
            wrote_ff <= 1'b0;
            cfg_ff <= `ADCIS_CFG_RST;
        end else begin
            if (state_ff == ADCIS_ADDR && scl_fall && bit_ff == 4'h8) rd_ff <= sh_in_ff[0];
            if (state_ff == ADCIS_WDAT && scl_fall && bit_ff == 4'h8) begin
                cfg_ff <= sh_in_ff;
                wrote_ff <= 1'b1;
            end else if (stop_c || start_c) begin
                wrote_ff <= 1'b0;
            end
        end
    end

    // transmit shifter: held until read, reloaded only when a conversion ends
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            sh_out_ff <= '0;
            rd_cnt_ff <= 6'h00;
        end else if (CONV_DONE && busy_ff) begin
            sh_out_ff <= CONV_RESULT;
            rd_cnt_ff <= 6'h00;
        end else if (scl_fall && state_ff == ADCIS_RDAT) begin
            // one shift per bit sent, so the byte's last bit leaves too
            sh_out_ff <= {sh_out_ff[`ADCIS_RES_W-2:0], 1'b0};
            rd_cnt_ff <= rd_cnt_ff + 6'h01;
        end
    end

    // open-drain sda drive, updated after falling scl, released on start or stop
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || start_c || stop_c) begin
            sda_o_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
        end else if (scl_fall) begin
            sda_o_ff <= 1'b0;
            case (nxt_state)
                ADCIS_AACK, ADCIS_WACK: sda_oe_ff <= 1'b1;
                // inside a byte the shifter moves on this same edge, so look one bit ahead
                ADCIS_RDAT: sda_oe_ff <= (state_ff == ADCIS_RDAT) ? ~sh_out_ff[`ADCIS_RES_W-2] :
                    ~sh_out_ff[`ADCIS_RES_W-1];
                default: sda_oe_ff <= 1'b0;
            endcase
        end
    end
    // the first read bit must come out at the ack fall, so take the top bit there with no look-ahead
    assign SDA_O = sda_o_ff;
    assign SDA_OE = sda_oe_ff;

    // conversion control: start after write+stop, after full read, or by software
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            busy_ff <= 1'b1;
            start_ff <= 1'b1;
        end else begin
            start_ff <= 1'b0;
            if (!busy_ff && ((stop_c && wrote_ff) || (rd_done && state_ff == ADCIS_RACK
                    && nxt_state == ADCIS_IDLE) || sw_start_ff)) begin
                start_ff <= 1'b1;
                busy_ff <= 1'b1;
            end else if (busy_ff && CONV_DONE) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // external clock detect: enough edges with no long gap
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            gap_ff <= 20'h00000;
            edges_ff <= 4'h0;
            ext_ff <= 1'b0;
        end else if (pin_edge) begin
            gap_ff <= 20'h00000;
            if (edges_ff != `ADCIS_EXT_EDGES) edges_ff <= edges_ff + 4'h1;
            else ext_ff <= 1'b1;
        end else if (gap_ff == 20'(`ADCIS_EXT_GAP_CYC)) begin
            edges_ff <= 4'h0; // slower than 10 kHz means strap, not clock
            ext_ff <= 1'b0;
        end else begin
            gap_ff <= gap_ff + 20'h00001;
        end
    end

    // filter null tick: one pulse per 5120 external clock rising edges
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST || !ext_ff) begin
            div_ff <= 13'h0000;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            if (pin_edge && ADDR_SEL_LO_OR_EXT_CLK_PIN) begin
                if (div_ff == 13'(`ADCIS_EXT_DIV - 1)) begin
                    div_ff <= 13'h0000;
                    tick_ff <= 1'b1;
                end else begin
                    div_ff <= div_ff + 13'h0001;
                end
            end
        end
    end

    // wishbone decode
    wire wb_req = WB_CYC_I & WB_STB_I & ~wb_ack_ff;
    wire wb_wr_stat = wb_req & WB_WE_I & (WB_ADR_I == `ADCIS_WB_STAT) & WB_SEL_I[0];
    wire [31:0] rd_mux = (WB_ADR_I == `ADCIS_WB_CFG) ? {24'h000000, cfg_ff} :
        (WB_ADR_I == `ADCIS_WB_STAT) ? {28'h0000000, rd_ff, ext_ff, 1'b0, busy_ff} :
        (WB_ADR_I == `ADCIS_WB_RES) ? sh_out_ff : 32'h00000000;

    // wishbone answer one cycle after request; status bit 1 write starts conversion
    always_ff @(posedge REF_CLK) begin
        if (SYS_RST) begin
            wb_ack_ff <= 1'b0;
            wb_dat_ff <= 32'h00000000;
            sw_start_ff <= 1'b0;
        end else begin
            wb_ack_ff <= wb_req;
            wb_dat_ff <= wb_req ? rd_mux : 32'h00000000;
            sw_start_ff <= wb_wr_stat & WB_DAT_I[1];
        end
    end

    assign WB_ACK_O = wb_ack_ff;
    assign WB_DAT_O = wb_dat_ff;
    assign CONV_START = start_ff;
    assign CONV_BUSY = busy_ff;
    assign EXT_CLK_SEL = ext_ff;
    assign NULL_TICK = tick_ff;
    assign CFG = cfg_ff;
endmodule

/* File: adcis_defs.svh */
// constants for the converter serial target port
`ifndef ADCIS_DEFS_SVH
`define ADCIS_DEFS_SVH
`define ADCIS_CLK_HZ 50000000
`define ADCIS_EXT_MIN_HZ 10000
// longest quiet gap on the shared pin that still counts as a clock (half period at 10 kHz)
`define ADCIS_EXT_GAP_CYC ((`ADCIS_CLK_HZ / `ADCIS_EXT_MIN_HZ) / 2)
`define ADCIS_EXT_EDGES 4'h8
`define ADCIS_EXT_DIV 5120
`define ADCIS_RES_BITS 6'h20
`define ADCIS_CFG_RST 8'h00
`define ADCIS_ADDR_BASE 7'h14
`define ADCIS_GLOBAL_ADDR 7'h77
`define ADCIS_WB_CFG 4'h0
`define ADCIS_WB_STAT 4'h4
`define ADCIS_WB_RES 4'h8
`define ADCIS_RES_W 32
`endif

/* File: adcis_pkg.sv */
// types for the converter serial target port
package adcis_pkg;
    typedef enum logic [2:0] {
        ADCIS_IDLE = 3'b000,
        ADCIS_ADDR = 3'b001,
        ADCIS_AACK = 3'b010,
        ADCIS_WDAT = 3'b011,
        ADCIS_WACK = 3'b100,
        ADCIS_RDAT = 3'b101,
        ADCIS_RACK = 3'b110
    } adcis_state_t;
    // configuration byte fields
    typedef struct packed {
        logic [3:0] rsvd;
        logic input_select_temp;
        logic reject_sel_a;
        logic reject_sel_b;
        logic speed_double;
    } adcis_cfg_t;
    // pin states of the address straps
    typedef struct packed {
        logic hi_low;
        logic hi_high;
        logic lo_high;
    } adcis_straps_t;
endpackage

/* File: adcis_port_chk.sv */
// assertions on the converter serial target port
`timescale 1ns/1ns
module adcis_port_chk (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // serial pins and core handshake
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic CONV_START,
    input wire logic CONV_BUSY,
    input wire logic EXT_CLK_SEL,
    input wire logic NULL_TICK,
    // bus handshake
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (SYS_RST);
    // pad may only pull the line down
    a_sda_low_only: assert property (SDA_OE |-> SDA_O == 1'b0)
        else $error("sda driven high");
    // data moves only while the serial clock is low
    a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_I)
        else $error("sda changed with scl high");
    a_busy_quiet: assert property (CONV_BUSY [*3] |-> !SDA_OE)
        else $error("sda driven while converting");
    a_start_busy: assert property (CONV_START |=> CONV_BUSY)
        else $error("start without busy");
    a_null_ext: assert property (NULL_TICK |-> EXT_CLK_SEL)
        else $error("null tick on internal clock");
    // reset leaves the line released and a conversion pending
    a_reset_state: assert property (disable iff (1'b0) SYS_RST |=> !SDA_OE && CONV_BUSY)
        else $error("bad state after reset");
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus ack late");
    a_ack_drop: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("bus ack held");
endmodule
bind adcis_port adcis_port_chk u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .SCL_I(SCL_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .CONV_START(CONV_START), .CONV_BUSY(CONV_BUSY),
    .EXT_CLK_SEL(EXT_CLK_SEL), .NULL_TICK(NULL_TICK), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O));

/* File: adcis_i2c_mst.sv */
// two-wire bus master model facing the converter port
`timescale 1ns/1ns
module adcis_i2c_mst (
    // clock and wire level
    input wire logic clk,
    input wire logic sda_in,
    // master drives; scl rests high between frames
    output logic scl,
    output logic sda_oe
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic ph(input int n);
        repeat (n) @(posedge clk);
    endtask
    // start or repeated start; only the master makes the clock
    task automatic start();
        sda_oe <= 1'b0;
        ph(2);
        scl <= 1'b1;
        ph(6);
        sda_oe <= 1'b1;
        ph(6);
        scl <= 1'b0;
    endtask
    // data set well inside the low phase, read at end of high phase
    task automatic bit_io(input logic b, output logic r);
        ph(2);
        sda_oe <= !b;
        ph(4);
        scl <= 1'b1;
        ph(6);
        r = sda_in;
        scl <= 1'b0;
    endtask
    // eight bits msb first, then the acknowledge slot
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ao);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ai, ao);
    endtask
    task automatic stop();
        ph(2);
        sda_oe <= 1'b1;
        ph(4);
        scl <= 1'b1;
        ph(6);
        sda_oe <= 1'b0;
        ph(6);
    endtask
endmodule

/* File: test_adcis_port.sv */
// self-checking bench for the converter serial target port
`timescale 1ns/1ns
`include "adcis_defs.svh"
`define CK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_adcis_port import adcis_pkg::*;;
    logic ref_clk = 1'b0, sys_rst = 1'b1, ext_pin = 1'b0, ext_on = 1'b0, done = 1'b0;
    logic cyc = 1'b0, we = 1'b0, ack, scl, m_oe, sda_oe, sda_o, sda, start, busy, ext_sel;
    logic tick, a;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, res = 32'h0;
    logic [7:0] q;
    adcis_straps_t straps = 3'b100;
    adcis_cfg_t cfg;
    int err_total = 0, checks = 0, cnt = 0;
    // open-drain wire with pull-up
    assign sda = !(m_oe || sda_oe);
    adcis_port DUT (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE(sda_oe), .STRAPS(straps), .ADDR_SEL_LO_OR_EXT_CLK_PIN(ext_pin),
        .CONV_DONE(done), .CONV_RESULT(res), .CONV_START(start), .CONV_BUSY(busy),
        .EXT_CLK_SEL(ext_sel), .NULL_TICK(tick), .CFG(cfg), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack));
    adcis_i2c_mst m (.clk(ref_clk), .sda_in(sda), .scl(scl), .sda_oe(m_oe));
    always #10 ref_clk = ~ref_clk;
    // external clock of eight cycles on the shared pin, and the hang guard
    always @(posedge ref_clk) begin
        cnt <= cnt + 1;
        if (ext_on && cnt[1:0] == 2'b00) ext_pin <= ~ext_pin;
        if (cnt == 95000) begin
            err_total++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d,
                      output logic [31:0] r);
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        sel <= 4'hf;
        wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic addr(input logic [6:0] ad, input logic rd);
        m.start();
        m.xfer({ad, rd}, 1'b1, q, a);
    endtask
    // core finishes; its result bus then moves on, the port must keep the word
    task automatic conv(input logic [31:0] r);
        res <= r;
        done <= 1'b1;
        @(posedge ref_clk);
        done <= 1'b0;
        res <= ~r;
        repeat (3) @(posedge ref_clk);
        `CK("busy", 1'b0, busy)
    endtask
    task automatic t_busy();
        `CK("busy rst", 1'b1, busy)
        addr(`ADCIS_ADDR_BASE, 1'b0);
        m.stop();
        `CK("busy nack", 1'b1, a)
        conv(32'h0);
    endtask
    task automatic t_write();
        addr(`ADCIS_ADDR_BASE, 1'b0);
        `CK("wr ack", 1'b0, a)
        m.xfer(8'h0d, 1'b1, q, a);
        `CK("cfg ack", 1'b0, a)
        m.stop();
        repeat (4) @(posedge ref_clk);
        `CK("cfg", 8'h0d, cfg)
        `CK("wr conv", 1'b1, busy)
        conv(32'h81a5_3c7e);
    endtask
    task automatic t_read();
        logic [31:0] w;
        addr(`ADCIS_ADDR_BASE + 7'h1, 1'b1);
        `CK("foreign", 1'b1, a)
        addr(`ADCIS_ADDR_BASE, 1'b1);
        `CK("rd ack", 1'b0, a)
        for (int i = 3; i >= 0; i--) begin
            m.xfer(8'hff, i == 0, q, a);
            w[i*8 +: 8] = q;
        end
        m.stop();
        `CK("word", 32'h81a5_3c7e, w)
        `CK("rd conv", 1'b1, busy)
        conv(32'h7f00_00c1);
    endtask
    task automatic t_wb();
        logic [31:0] r;
        wb(1'b0, 4'h8, 32'h0, r);
        `CK("held", 32'h7f00_00c1, r)
        wb(1'b1, 4'hc, 32'hffff_ffff, r);
        wb(1'b0, 4'hc, 32'h0, r);
        `CK("unmapped", 32'h0, r)
        wb(1'b1, 4'h4, 32'h2, r);
        wb(1'b0, 4'h4, 32'h0, r);
        `CK("sw busy", 1'b1, r[0])
        conv(32'h0);
    endtask
    task automatic t_ext();
        int n;
        ext_on <= 1'b1;
        repeat (400) @(posedge ref_clk);
        `CK("ext sel", 1'b1, ext_sel)
        addr(`ADCIS_ADDR_BASE + 7'h1, 1'b0);
        `CK("lo forced", 1'b0, a)
        m.xfer(8'h00, 1'b1, q, a);
        m.stop();
        while (tick !== 1'b1) @(posedge ref_clk);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (tick !== 1'b1);
        `CK("tick gap", `ADCIS_EXT_DIV * 8, n)
        ext_on <= 1'b0;
        repeat (2700) @(posedge ref_clk);
        `CK("ext lost", 1'b0, ext_sel)
        conv(32'h0);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_busy();
        t_write();
        t_read();
        t_wb();
        t_ext();
        stop_test();
    end
endmodule
